// >>> shared/hep0_pkg.sv
// Purpose: shared constants and carrier types for the hub endpoint 0 status and buffer block
// Assumes: 8-bit register port, byte addresses, one clock
// Notes:   register addresses, field positions and sizes are named here once
package hep0_pkg;
    // =====================================================
    // register map
    localparam logic [7:0] buf_base_addr   = 8'h30;  // ep0_buffer_byte0
    localparam logic [7:0] buf_last_addr   = 8'h37;  // ep0_buffer_byte7
    localparam logic [7:0] status_addr     = 8'h3d;  // hub_ep0_status
    localparam logic [7:0] control_addr    = 8'h3c;  // transmit size and enables
    localparam logic [7:0] irq_stat_addr   = 8'h3e;  // sticky events, read clears
    localparam logic [7:0] irq_mask_addr   = 8'h3f;  // event mask
    // =====================================================
    // status register field positions
    localparam int stat_toggle_bit  = 7;  // rx_toggle_indicator
    localparam int stat_setup_bit   = 6;  // setup indicator
    localparam int stat_txfirst_bit = 5;  // transmit_first_flag
    localparam int stat_clear_bit   = 4;  // transmit_first_clear (write only)
    // control register field positions
    localparam int ctl_txe_bit      = 7;  // transmit enable
    localparam int ctl_rxe_bit      = 6;  // receive enable
    localparam int ctl_txdfr_bit    = 5;  // transmit complete clear (write only)
    localparam int ctl_rxdfr_bit    = 4;  // receive complete clear (write only)
    // interrupt bit positions
    localparam int irq_rx_bit       = 0;  // reception done
    localparam int irq_tx_bit       = 1;  // transmission done
    localparam int irq_first_bit    = 2;  // transmit first seen
    // =====================================================
    // sizes and reset values
    localparam int          buf_depth      = 8;      // bytes per packet
    localparam logic [3:0]  max_count      = 4'h8;   // largest packet
    localparam logic [7:0]  ctl_reset      = 8'h00;  // control after reset
    localparam logic [2:0]  irq_reset      = 3'h0;   // interrupt state after reset
    // =====================================================
    // link side transaction events from the serial engine
    typedef struct packed {
        logic       rx_byte;     // one received byte valid
        logic [7:0] rx_data;     // received byte
        logic       rx_done;     // data packet received and acked
        logic       rx_setup;    // packet followed a setup token
        logic       rx_toggle;   // packet was DATA1
        logic       tx_byte;     // engine took one byte
        logic       tx_done;     // host acked our data
        logic       tx_start;    // new in packet begins
    } hep0_link_t;
    // cpu register port
    typedef struct packed {
        logic [7:0] addr;        // byte address
        logic [7:0] wdata;       // write data
        logic       wr;          // write strobe
        logic       rd;          // read strobe
    } hep0_bus_t;
endpackage : hep0_pkg

// >>> design/hep0_bytebuf.sv
// Purpose: eight byte buffer with registered read
// Assumes: one writer and one reader port on the same clock
// Notes:   contents not reset, as the buffer bytes read indeterminate
`timescale 1ns/10ps
`default_nettype none
module hep0_bytebuf (
    input  wire logic       clock,
    input  wire logic       we,
    input  wire logic [2:0] waddr,
    input  wire logic [7:0] wdata,
    input  wire logic [2:0] raddr,
    output var  logic [7:0] rdata
);
    // =====================================================
    // storage
    logic [7:0] mem [0:hep0_pkg::buf_depth-1];  // byte cells
    // write and registered read
    always_ff @(posedge clock) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : hep0_bytebuf
`default_nettype wire

// >>> design/hep0_flag.sv
// Purpose: one sticky flag, set by hardware and cleared by a pulse
// Assumes: set and clear on the same clock
// Notes:   set wins over clear in the same cycle
`timescale 1ns/10ps
`default_nettype none
module hep0_flag (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic set,
    input  wire logic clr,
    output var  logic flag
);
    // =====================================================
    // sticky state
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            flag <= 1'b0;
        end else if (set) begin
            flag <= 1'b1;
        end else if (clr) begin
            flag <= 1'b0;
        end
    end
endmodule : hep0_flag
`default_nettype wire

// >>> design/hep0_top.sv
// Purpose: hub endpoint 0 status, receive buffer and transmit buffer
// Assumes: serial engine on the same clock delivers byte and packet events
// Notes:   cpu reaches registers over a plain strobe port, read data one cycle later
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module hep0_top (
    input  wire logic                clock,
    input  wire logic                sys_rst,
    input  wire hep0_pkg::hep0_bus_t bus,
    output var  logic [7:0]          rdata,
    input  wire hep0_pkg::hep0_link_t link,
    output var  logic [7:0]          tx_data,
    output logic                     tx_last,
    output logic                     tx_ready,
    output logic                     rx_ready,
    output logic                     irq
);
    // =====================================================
    // register state
    logic [7:0] ctl;           // txe, rxe, size in low nibble
    logic       toggle;        // last data type
    logic       setup;         // last token was setup
    logic [3:0] rx_count;      // received byte count
    logic [2:0] rx_ptr;        // receive write index
    logic [2:0] tx_ptr;        // transmit read index
    logic [3:0] tx_sent;       // bytes sent in current packet
    logic [2:0] irq_mask;      // interrupt mask
    logic       rx_flag;       // receive_complete_flag
    logic       tx_flag;       // transmit_complete_flag
    logic       first_flag;    // transmit_first_flag
    logic [2:0] irq_stat;      // sticky events
    logic [7:0] rx_rdata;      // receive buffer read port
    logic [7:0] tx_rdata;      // transmit buffer read port
    logic [7:0] sel_q;         // registered non buffer read value
    logic       buf_rd_q;      // last read hit buffer
    // =====================================================
    // address decode
    wire hit_buf  = (bus.addr >= hep0_pkg::buf_base_addr) && (bus.addr <= hep0_pkg::buf_last_addr);
    wire hit_stat = bus.addr == hep0_pkg::status_addr;
    wire hit_ctl  = bus.addr == hep0_pkg::control_addr;
    wire hit_irq  = bus.addr == hep0_pkg::irq_stat_addr;
    wire hit_msk  = bus.addr == hep0_pkg::irq_mask_addr;
    wire wr_stat  = bus.wr && hit_stat;
    wire wr_ctl   = bus.wr && hit_ctl;
    wire rd_irq   = bus.rd && hit_irq;
    wire [2:0] buf_index = bus.addr[2:0];
    // write only clear pulses
    wire clr_first = wr_stat && bus.wdata[hep0_pkg::stat_clear_bit];
    wire clr_rx    = wr_ctl && bus.wdata[hep0_pkg::ctl_rxdfr_bit];
    wire clr_tx    = wr_ctl && bus.wdata[hep0_pkg::ctl_txdfr_bit];
    // size clamped to the buffer
    wire [3:0] tx_size = (ctl[3:0] > hep0_pkg::max_count) ? hep0_pkg::max_count : ctl[3:0];
    // events
    wire set_first = link.rx_done && tx_flag;
    // the limit counts the packet in flight, not the reset-free count of the last one
    logic [3:0] rx_run;  // bytes of the packet in flight
    wire rx_accept = link.rx_byte && rx_ready && (rx_run < hep0_pkg::max_count);
    // =====================================================
    // handshake readiness toward the engine
    assign rx_ready = ctl[hep0_pkg::ctl_rxe_bit] && !rx_flag;
    assign tx_ready = ctl[hep0_pkg::ctl_txe_bit] && !tx_flag;
    assign tx_last  = (tx_sent + 4'h1) >= tx_size;
    assign irq      = |(irq_stat & irq_mask);
    // =====================================================
    // flags
    hep0_flag u_rx_flag (
        .clock   (clock),
        .sys_rst (sys_rst),
        .set     (link.rx_done),
        .clr     (clr_rx),
        .flag    (rx_flag)
    );
    hep0_flag u_tx_flag (
        .clock   (clock),
        .sys_rst (sys_rst),
        .set     (link.tx_done),
        .clr     (clr_tx),
        .flag    (tx_flag)
    );
    hep0_flag u_first_flag (
        .clock   (clock),
        .sys_rst (sys_rst),
        .set     (set_first),
        .clr     (clr_first),
        .flag    (first_flag)
    );
    // =====================================================
    // buffers: receive read by cpu, transmit read by engine
    hep0_bytebuf u_rx_buf (
        .clock (clock),
        .we    (rx_accept),
        .waddr (rx_ptr),
        .wdata (link.rx_data),
        .raddr (buf_index),
        .rdata (rx_rdata)
    );
    wire [2:0] tx_raddr = link.tx_start ? 3'h0 : (link.tx_byte ? tx_ptr + 3'h1 : tx_ptr);
    hep0_bytebuf u_tx_buf (
        .clock (clock),
        .we    (bus.wr && hit_buf),
        .waddr (buf_index),
        .wdata (bus.wdata),
        .raddr (tx_raddr),
        .rdata (tx_rdata)
    );
    assign tx_data = tx_rdata;
    // =====================================================
    // control and mask registers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ctl      <= hep0_pkg::ctl_reset;
            irq_mask <= hep0_pkg::irq_reset;
        end else begin
            if (wr_ctl) begin
                ctl <= {bus.wdata[7:6], 2'h0, bus.wdata[3:0]};
            end
            if (bus.wr && hit_msk) begin
                irq_mask <= bus.wdata[2:0];
            end
        end
    end
    // =====================================================
    // reception status, cleared by reset except the count
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            toggle <= 1'b0;
            setup  <= 1'b0;
            rx_ptr <= 3'h0;
        end else if (link.rx_done) begin
            toggle <= link.rx_toggle;
            setup  <= link.rx_setup;
            rx_ptr <= 3'h0;
        end else if (rx_accept) begin
            rx_ptr <= rx_ptr + 3'h1;
        end
    end
    // count keeps its value through reset
    always_ff @(posedge clock) begin
        if (link.rx_done) begin
            rx_count <= rx_run;
        end
    end
    // running byte count, reset so that the first packet after power-up is counted
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rx_run <= 4'h0;
        end else if (link.rx_done) begin
            rx_run <= 4'h0;
        end else if (rx_accept) begin
            rx_run <= rx_run + 4'h1;
        end
    end
    // =====================================================
    // transmit pointer
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tx_ptr  <= 3'h0;
            tx_sent <= 4'h0;
        end else if (link.tx_start) begin
            tx_ptr  <= 3'h0;
            tx_sent <= 4'h0;
        end else if (link.tx_byte && !tx_last) begin
            tx_ptr  <= tx_ptr + 3'h1;
            tx_sent <= tx_sent + 4'h1;
        end
    end
    // =====================================================
    // interrupt status, set wins over read clear
    wire [2:0] irq_set = {set_first, link.tx_done, link.rx_done};
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            irq_stat <= hep0_pkg::irq_reset;
        end else begin
            irq_stat <= irq_set | (rd_irq ? 3'h0 : irq_stat);
        end
    end
    // =====================================================
    // read path
    wire [7:0] stat_val = {toggle, setup, first_flag, 1'b0, rx_count};
    wire [7:0] ctl_val  = {ctl[7:6], 2'h0, ctl[3:0]};
    wire [7:0] sel_val  = hit_stat ? stat_val :
                          hit_ctl  ? ctl_val :
                          hit_irq  ? {5'h00, irq_stat} :
                          hit_msk  ? {5'h00, irq_mask} : 8'h00;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sel_q    <= 8'h00;
            buf_rd_q <= 1'b0;
        end else begin
            sel_q    <= bus.rd ? sel_val : 8'h00;
            buf_rd_q <= bus.rd && hit_buf;
        end
    end
    assign rdata = buf_rd_q ? rx_rdata : sel_q;
    // =====================================================
    // checks
    a_first_set: assert property (@(posedge clock) disable iff (sys_rst)
        set_first |=> first_flag)
        else $error("first flag not set");
    a_first_hold: assert property (@(posedge clock) disable iff (sys_rst)
        (first_flag && !clr_first) |=> first_flag)
        else $error("first flag dropped");
    a_first_clear: assert property (@(posedge clock) disable iff (sys_rst)
        (clr_first && !set_first) |=> !first_flag)
        else $error("first flag not cleared");
    a_zero_noclr: assert property (@(posedge clock) disable iff (sys_rst)
        (wr_stat && !bus.wdata[4] && first_flag) |=> first_flag)
        else $error("zero write cleared flag");
    a_toggle_cap: assert property (@(posedge clock) disable iff (sys_rst)
        link.rx_done |=> (stat_val[7] == $past(link.rx_toggle)) && (stat_val[6] == $past(link.rx_setup)))
        else $error("toggle or setup wrong");
    a_count_cap: assert property (@(posedge clock) disable iff (sys_rst)
        link.rx_done |=> rx_count == $past(rx_run))
        else $error("count wrong");
    a_count_max: assert property (@(posedge clock) disable iff (sys_rst)
        rx_run <= hep0_pkg::max_count)
        else $error("packet over eight");
    a_rx_done: assert property (@(posedge clock) disable iff (sys_rst)
        link.rx_done |=> rx_flag && !rx_ready)
        else $error("receive flag missing");
    a_tx_done: assert property (@(posedge clock) disable iff (sys_rst)
        link.tx_done |=> tx_flag && !tx_ready)
        else $error("transmit flag missing");
    a_irq_level: assert property (@(posedge clock) disable iff (sys_rst)
        link.rx_done && irq_mask[0] |=> irq)
        else $error("irq missing");
    c_first: cover property (@(posedge clock) disable iff (sys_rst) set_first);
    c_rx_full: cover property (@(posedge clock) disable iff (sys_rst) link.rx_done && rx_run == 4'h8);
    c_tx_last: cover property (@(posedge clock) disable iff (sys_rst) link.tx_byte && tx_last);
endmodule : hep0_top
`default_nettype wire

// >>> test/hep0_host_model.sv
// Purpose: host controller model that drives the endpoint 0 link events
// Assumes: same clock as the block, every event changes just after a rising edge
// Notes:   released data and level lines show the inverse of their last value
`timescale 1ns/10ps
`default_nettype none
module hep0_host_model (
    input  wire logic                 clock,
    input  wire logic [7:0]           tx_data,
    input  wire logic                 tx_last,
    output var  hep0_pkg::hep0_link_t link
);
    // =====================================================
    // idle link at time zero
    initial link = '0;

    // =====================================================
    // out or setup data stage: bytes back to back, then the acked end
    task automatic out_txn(input logic setup, input logic tog, input int n, input logic [7:0] b [9]);
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            link.rx_byte <= 1'b1;
            link.rx_data <= b[i];
        end
        @(posedge clock);
        link.rx_byte   <= 1'b0;
        link.rx_data   <= ~link.rx_data;
        link.rx_done   <= 1'b1;
        link.rx_setup  <= setup;
        link.rx_toggle <= tog;
        @(posedge clock);
        link.rx_done   <= 1'b0;
        link.rx_setup  <= ~setup;
        link.rx_toggle <= ~tog;
    endtask : out_txn

    // =====================================================
    // in transaction: take bytes until the last one, then acknowledge
    task automatic in_txn(output logic [7:0] got [8], output int cnt);
        cnt = 0;
        @(posedge clock);
        link.tx_start <= 1'b1;
        @(posedge clock);
        link.tx_start <= 1'b0;
        forever begin
            #1;
            got[cnt] = tx_data;
            cnt++;
            if (tx_last === 1'b1 || cnt == 8) break;
            @(posedge clock);
            link.tx_byte <= 1'b1;
            @(posedge clock);
            link.tx_byte <= 1'b0;
        end
        @(posedge clock);
        link.tx_done <= 1'b1;
        @(posedge clock);
        link.tx_done <= 1'b0;
    endtask : in_txn
endmodule : hep0_host_model
`default_nettype wire

// >>> test/tb_hub_ep0_status_and_buffers.sv
// Purpose: self-checking bench for the endpoint 0 status and buffer block
// Assumes: host model on the link side, register reads checked from a queue
// Notes:   random packet lengths and contents from a fixed seed
`timescale 1ns/10ps
`default_nettype none
module tb_hub_ep0_status_and_buffers;
    logic                 clock   = 1'b0;  // 10 MHz
    logic                 sys_rst = 1'b1;  // held at start
    hep0_pkg::hep0_bus_t  bus     = '0;    // register port
    hep0_pkg::hep0_link_t link;            // host model events
    logic [7:0]           rdata, tx_data;
    logic                 tx_last, tx_ready, rx_ready, irq;
    int                   num_errors  = 0;
    int                   checks_done = 0;
    logic [7:0]           exp_q [$];       // expected read data
    logic [7:0]           msk_q [$];       // bits that matter
    logic                 rd_d = 1'b0;     // read taken last edge
    logic [7:0]           mon_m;
    logic [7:0]           pkt [9];
    logic [7:0]           got [8];
    int                   n, cnt;

    always #50 clock = ~clock;

    hep0_top u_dut (.clock(clock), .sys_rst(sys_rst), .bus(bus), .rdata(rdata), .link(link),
        .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .rx_ready(rx_ready), .irq(irq));
    hep0_host_model u_host (.clock(clock), .tx_data(tx_data), .tx_last(tx_last), .link(link));

    // =====================================================
    // compare and report
    task automatic chk(input logic [7:0] act, input logic [7:0] exp);
        checks_done++;
        if (act !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, act, exp);
        end
    endtask : chk

    task automatic stop_test;
        if (num_errors == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : stop_test

    // one-cycle register write and read strobes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge clock);
        bus.wr    <= 1'b0;
    endtask : wr

    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge clock);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge clock);
        bus.rd   <= 1'b0;
    endtask : rd_exp

    // =====================================================
    // read data stand one cycle after the strobe: compare the oldest note
    always @(posedge clock) begin
        if (rd_d) begin
            mon_m = msk_q.pop_front();
            chk(rdata & mon_m, exp_q.pop_front() & mon_m);
        end
        rd_d <= bus.rd;
    end

    // watchdog
    initial begin
        #(3000 * 100);
        num_errors++;
        stop_test();
    end

    // =====================================================
    // main sequence
    initial begin
        void'($urandom(89));
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        rd_exp(hep0_pkg::status_addr, 8'h00, 8'h30);
        rd_exp(hep0_pkg::control_addr, hep0_pkg::ctl_reset, 8'hff);
        rd_exp(hep0_pkg::irq_mask_addr, 8'h00, 8'h07);
        rd_exp(8'h50, 8'h00, 8'hff);
        wr(hep0_pkg::irq_mask_addr, 8'h07);
        wr(hep0_pkg::control_addr, 8'h40);
        // every setup and toggle pair, the last one over-long
        for (int k = 0; k < 4; k++) begin
            n = (k == 3) ? 9 : 1 + $urandom % 8;
            foreach (pkt[i]) pkt[i] = 8'($urandom);
            u_host.out_txn(k[1], k[0], n, pkt);
            #1;
            chk({7'h0, irq}, 8'h01);
            rd_exp(hep0_pkg::status_addr, {k[0], k[1], 2'b00, 4'((n > 8) ? 8 : n)}, 8'hff);
            for (int i = 0; i < n && i < 8; i++) rd_exp(hep0_pkg::buf_base_addr + 8'(i), pkt[i], 8'hff);
            rd_exp(hep0_pkg::irq_stat_addr, 8'h01, 8'h07);
            wr(hep0_pkg::control_addr, 8'h50);
            #1;
            chk({7'h0, irq}, 8'h00);
        end
        // transmit buffer sent on the next in, sized by the size field
        n = 1 + $urandom % 8;
        foreach (got[i]) pkt[i] = 8'($urandom);
        for (int i = 0; i < 8; i++) wr(hep0_pkg::buf_base_addr + 8'(i), pkt[i]);
        wr(hep0_pkg::control_addr, {4'hc, 4'(n)});
        #1;
        chk({7'h0, tx_ready}, 8'h01);
        u_host.in_txn(got, cnt);
        chk(8'(cnt), 8'(n));
        for (int i = 0; i < n; i++) chk(got[i], pkt[i]);
        #1;
        chk({7'h0, tx_ready}, 8'h00);
        rd_exp(hep0_pkg::irq_stat_addr, 8'h02, 8'h07);
        // reception while the transmit flag is unserviced
        u_host.out_txn(1'b0, 1'b0, 2, pkt);
        rd_exp(hep0_pkg::status_addr, 8'h22, 8'hff);
        wr(hep0_pkg::status_addr, 8'h00);
        rd_exp(hep0_pkg::status_addr, 8'h22, 8'hff);
        wr(hep0_pkg::status_addr, 8'h10);
        rd_exp(hep0_pkg::status_addr, 8'h02, 8'hff);
        rd_exp(hep0_pkg::irq_stat_addr, 8'h05, 8'h07);
        // second reset keeps the received count
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        rd_exp(hep0_pkg::status_addr, 8'h02, 8'h3f);
        repeat (3) @(posedge clock);
        stop_test();
    end
endmodule : tb_hub_ep0_status_and_buffers
`default_nettype wire
